// ===== strap_latch_defines.vh
// Constants for the hub reset strap latch
`ifndef STRAP_LATCH_DEFINES_VH
`define STRAP_LATCH_DEFINES_VH
`define NUM_PORTS_DEFAULT    4
`define RESET_MIN_NS         1000
`define CLK_PERIOD_NS        4
`define RESET_MIN_CYCLES     ((`RESET_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FIXED_CODE_NONE      2'h0
`define FIXED_CODE_P1        2'h1
`define FIXED_CODE_P12       2'h2
`define FIXED_CODE_P123      2'h3
`define FIXED_CODE_BIT1      1
`define FIXED_CODE_BIT0      0
`define OC_FILTER_DEFAULT    2
`endif

// ===== strap_sample_reg.v
// Capture register that samples a strap vector once after reset release
`timescale 1ns/10ps
module strap_sample_reg
#(
  parameter WIDTH = 8
)
(
  // Clock and synchronised reset
  input  wire             core_clk_i,
  input  wire             rst_b_i,
  // Capture strobe and data
  input  wire             capture_i,
  input  wire [WIDTH-1:0] data_i,
  output reg  [WIDTH-1:0] data_o
);

  // Loads only on the single capture strobe, then holds until reset
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      data_o <= {WIDTH{1'b0}};
    else if (capture_i)
      data_o <= data_i;
  end

endmodule // strap_sample_reg

// ===== hub_reset_strap_latch.v
// Reset synchroniser and strap latch for a hub controller
//
// Summary of operation
// - Sample both port data strap pins at release.
// - Port disabled only when both pins high.
// - Sample power-enable pin for charge support.
// - Charge-capable port uses external power controller.
// - Fixed code bit1 serial data, bit0 indicator.
// - Decode code into fixed port mask.
// - Any fixed port means compound device.
// - Low reset resets all; hold 1 us.
// - Latch config select bit 0 from clock pin.
// - Drive per-port power enable outputs.
// - Low over-current input flags that port.
// - Names ending low-suffix assert at low level.
// - Latch config select bit 1 same edge.
//
// Timing after the external reset is released, counted in clock edges:
//   edge 1  first synchroniser stage sets
//   edge 2  internal reset lifts
//   edge 3  strap pins are captured into the sample register
//   edge 4  strap results and straps_valid_o are presented
//   edge 5  port_power_enable_o may rise for requested ports
// The pins must therefore stand at their strap level for three edges
// after release. The board pull resistors give that, as long as nothing
// else drives the shared lines so early after reset.
// Reset assertion is asynchronous and clears every output at once.
// Power is refused until the straps are valid, so a port that is
// strapped off never sees even a single cycle of power.
`include "strap_latch_defines.vh"
`timescale 1ns/10ps
module hub_reset_strap_latch
#(
  parameter NUM_PORTS = `NUM_PORTS_DEFAULT,
  parameter OC_FILTER = `OC_FILTER_DEFAULT
)
(
  // Clock and external reset
  input  wire                 core_clk_i,
  input  wire                 rst_b_i,
  // Strap pins sampled at reset release
  input  wire                 strapping_enable_i,
  input  wire [NUM_PORTS-1:0] port_off_strap_plus_i,
  input  wire [NUM_PORTS-1:0] port_off_strap_minus_i,
  input  wire [NUM_PORTS-1:0] charge_support_strap_i,
  input  wire                 fixed_port_code_bit1_i,
  input  wire                 fixed_port_code_bit0_i,
  input  wire                 config_method_sel0_i,
  input  wire                 config_method_sel1_i,
  // Port power requests from the hub core and sense inputs
  input  wire [NUM_PORTS-1:0] power_request_i,
  input  wire [NUM_PORTS-1:0] overcurrent_sense_low_i,
  // Latched strap results
  output reg                  straps_valid_o,
  output reg  [NUM_PORTS-1:0] port_disabled_o,
  output reg  [NUM_PORTS-1:0] charge_support_o,
  output reg  [NUM_PORTS-1:0] ext_power_ctrl_o,
  output reg  [1:0]           fixed_port_code_o,
  output reg  [NUM_PORTS-1:0] fixed_port_mask_o,
  output reg                  compound_device_o,
  output reg  [1:0]           config_method_sel_o,
  // Port power and over-current status
  output reg  [NUM_PORTS-1:0] port_power_enable_o,
  output reg  [NUM_PORTS-1:0] overcurrent_o
);

  localparam STRAP_W = 3 * NUM_PORTS + 4;
  localparam OC_CW   = 4;

  // Field positions inside the captured strap word, top field first; the
  // low NUM_PORTS bits are spare padding that always captures zero
  localparam DIS_MSB  = STRAP_W - 1;
  localparam BC_MSB   = 2 * NUM_PORTS + 3;
  localparam CODE_MSB = NUM_PORTS + 3;
  localparam SEL_MSB  = NUM_PORTS + 1;

  // Filter limit and increment at the counter's own width
  localparam [OC_CW-1:0] OC_LIMIT = OC_FILTER[OC_CW-1:0];
  localparam [OC_CW-1:0] OC_ONE   = {{(OC_CW-1){1'b0}}, 1'b1};

  // Decode of the fixed-port code into a per-port mask
  function [NUM_PORTS-1:0] fixed_mask;
    input [1:0] code;
    integer     k;
    begin
      fixed_mask = {NUM_PORTS{1'b0}};
      for (k = 0; k < NUM_PORTS; k = k + 1)
      begin
        case (code)
          `FIXED_CODE_P1:   fixed_mask[k] = (k < 1);
          `FIXED_CODE_P12:  fixed_mask[k] = (k < 2);
          `FIXED_CODE_P123: fixed_mask[k] = (k < 3);
          default:          fixed_mask[k] = 1'b0;
        endcase
      end
    end
  endfunction

  reg  rst_sync1_reg;
  reg  rst_sync2_reg;
  reg  captured_reg;
  wire rst_b;
  wire capture;
  wire [STRAP_W-1:0] strap_raw;
  wire [STRAP_W-1:0] strap_held;
  wire [NUM_PORTS-1:0] dis_raw;
  wire [NUM_PORTS-1:0] bc_raw;

  // Reset release through two flip-flops; assert is immediate
  always @(posedge core_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i) // Low level asserts reset
    begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end
    else
    begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_b = rst_sync2_reg;

  // One capture strobe in the first cycle after release
  always @(posedge core_clk_i or negedge rst_b)
  begin
    if (!rst_b)
      captured_reg <= 1'b0;
    else
      captured_reg <= 1'b1;
  end
  assign capture = ~captured_reg;

  // Port-off and charge straps are ignored when strapping is off, giving all ports on
  assign dis_raw = strapping_enable_i ?
                   (port_off_strap_plus_i & port_off_strap_minus_i) : {NUM_PORTS{1'b0}};
  assign bc_raw  = strapping_enable_i ? charge_support_strap_i : {NUM_PORTS{1'b0}};
  assign strap_raw = {dis_raw,
                      bc_raw,
                      fixed_port_code_bit1_i,
                      fixed_port_code_bit0_i,
                      config_method_sel1_i,
                      config_method_sel0_i,
                      {NUM_PORTS{1'b0}}};

  // Pins are sampled once; later pin activity cannot disturb them
  strap_sample_reg #(
    .WIDTH (STRAP_W)
  ) u_sample (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b),
    .capture_i  (capture),
    .data_i     (strap_raw),
    .data_o     (strap_held)
  );

  // Named views of the fields held in the capture register
  wire [NUM_PORTS-1:0] held_disabled;
  wire [NUM_PORTS-1:0] held_charge;
  wire [1:0]           held_code;
  wire [1:0]           held_sel;
  assign held_disabled = strap_held[DIS_MSB -: NUM_PORTS];
  assign held_charge   = strap_held[BC_MSB -: NUM_PORTS];
  assign held_code     = strap_held[CODE_MSB -: 2];
  assign held_sel      = strap_held[SEL_MSB -: 2];

  // Next values of the strap results
  reg                 straps_valid_next;
  reg [NUM_PORTS-1:0] port_disabled_next;
  reg [NUM_PORTS-1:0] charge_support_next;
  reg [NUM_PORTS-1:0] ext_power_ctrl_next;
  reg [1:0]           fixed_port_code_next;
  reg [NUM_PORTS-1:0] fixed_port_mask_next;
  reg                 compound_device_next;
  reg [1:0]           config_method_sel_next;

  // Decodes come from the held word, never from the live pins, so they
  // cannot drift once the strap pins turn into data lines
  always @*
  begin
    straps_valid_next      = captured_reg;
    port_disabled_next     = held_disabled;
    charge_support_next    = held_charge;
    ext_power_ctrl_next    = held_charge;
    fixed_port_code_next   = held_code;
    fixed_port_mask_next   = fixed_mask(held_code);
    compound_device_next   = (held_code != `FIXED_CODE_NONE);
    config_method_sel_next = held_sel;
  end

  // Latched outputs and their derived decodes, valid one cycle after capture
  always @(posedge core_clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      straps_valid_o      <= 1'b0;
      port_disabled_o     <= {NUM_PORTS{1'b0}};
      charge_support_o    <= {NUM_PORTS{1'b0}};
      ext_power_ctrl_o    <= {NUM_PORTS{1'b0}};
      fixed_port_code_o   <= `FIXED_CODE_NONE;
      fixed_port_mask_o   <= {NUM_PORTS{1'b0}};
      compound_device_o   <= 1'b0;
      config_method_sel_o <= 2'h0;
    end
    else
    begin
      straps_valid_o      <= straps_valid_next;
      port_disabled_o     <= port_disabled_next;
      charge_support_o    <= charge_support_next;
      ext_power_ctrl_o    <= ext_power_ctrl_next;
      fixed_port_code_o   <= fixed_port_code_next;
      fixed_port_mask_o   <= fixed_port_mask_next;
      compound_device_o   <= compound_device_next;
      config_method_sel_o <= config_method_sel_next;
    end
  end

  // Per-port filter results: sense held low for the full filter time
  wire [NUM_PORTS-1:0] oc_hit;

  // Per-port over-current glitch filter. A short dip on the sense line is
  // ignored; the price is OC_FILTER cycles of extra latency before a port
  // is flagged, far below the time an external monitor allows
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1)
    begin : g_port
      reg [OC_CW-1:0] oc_cnt_reg;
      reg [OC_CW-1:0] oc_cnt_next;

      // Count cycles of a continuously low sense line, saturating
      always @*
      begin
        oc_cnt_next = oc_cnt_reg;
        if (overcurrent_sense_low_i[g]) // High is idle
          oc_cnt_next = {OC_CW{1'b0}};
        else if (oc_cnt_reg != OC_LIMIT)
          oc_cnt_next = oc_cnt_reg + OC_ONE;
      end

      // Filter counter register
      always @(posedge core_clk_i or negedge rst_b)
      begin
        if (!rst_b)
          oc_cnt_reg <= {OC_CW{1'b0}};
        else
          oc_cnt_reg <= oc_cnt_next;
      end

      // Flag drops at once when the line returns high, so recovery is fast
      assign oc_hit[g] = ~overcurrent_sense_low_i[g] & (oc_cnt_reg == OC_LIMIT);
    end
  endgenerate

  // Next values of the port status outputs
  reg [NUM_PORTS-1:0] overcurrent_next;
  reg [NUM_PORTS-1:0] port_power_enable_next;

  // Power only to enabled, valid, fault-free ports; a fault cuts power one
  // cycle after it is flagged, the cost of keeping outputs on flops
  always @*
  begin
    overcurrent_next       = oc_hit;
    port_power_enable_next = power_request_i & {NUM_PORTS{straps_valid_o}} &
                             ~port_disabled_o & ~overcurrent_o;
  end

  // Port status registers; each output comes straight from one flop
  always @(posedge core_clk_i or negedge rst_b)
  begin
    if (!rst_b)
    begin
      overcurrent_o       <= {NUM_PORTS{1'b0}};
      port_power_enable_o <= {NUM_PORTS{1'b0}};
    end
    else
    begin
      overcurrent_o       <= overcurrent_next;
      port_power_enable_o <= port_power_enable_next;
    end
  end

endmodule // hub_reset_strap_latch

// ===== strap_latch_chk.sv
// Assertion checker for the hub reset strap latch
`timescale 1ns/10ps
module strap_latch_chk
(
  // Clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_b_i,
  // Port inputs and results
  input wire logic [3:0] power_request_i,
  input wire logic [3:0] overcurrent_sense_low_i,
  input wire logic       straps_valid_o,
  input wire logic [3:0] port_disabled_o,
  input wire logic [3:0] charge_support_o,
  input wire logic [3:0] ext_power_ctrl_o,
  input wire logic [1:0] fixed_port_code_o,
  input wire logic [3:0] fixed_port_mask_o,
  input wire logic       compound_device_o,
  input wire logic [1:0] config_method_sel_o,
  input wire logic [3:0] port_power_enable_o,
  input wire logic [3:0] overcurrent_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  // Strap results and their derived flags
  property p_ext; ext_power_ctrl_o == charge_support_o; endproperty
  a_ext: assert property (p_ext) else $error("ext ctrl");
  property p_cmp; compound_device_o == (fixed_port_code_o != 2'h0); endproperty
  a_cmp: assert property (p_cmp) else $error("compound");
  property p_mask; fixed_port_mask_o == {1'b0, &fixed_port_code_o, fixed_port_code_o[1], |fixed_port_code_o}; endproperty
  a_mask: assert property (p_mask) else $error("mask");
  property p_hold; $past(straps_valid_o) |-> $stable({port_disabled_o, charge_support_o, config_method_sel_o}); endproperty
  a_hold: assert property (p_hold) else $error("strap moved");
  property p_zero; !straps_valid_o |-> ({port_disabled_o, charge_support_o, port_power_enable_o} == 12'h000); endproperty
  a_zero: assert property (p_zero) else $error("early result");
  // Power and over-current; the run of six leaves room for the filter
  property p_pwr; (port_power_enable_o & (port_disabled_o | ~$past(power_request_i))) == 4'h0; endproperty
  a_pwr: assert property (p_pwr) else $error("power");
  property p_ocs; !overcurrent_sense_low_i[0] [*6] |-> overcurrent_o[0]; endproperty
  a_ocs: assert property (p_ocs) else $error("oc set");
  property p_ocf; overcurrent_sense_low_i[0] |=> !overcurrent_o[0]; endproperty
  a_ocf: assert property (p_ocf) else $error("oc clear");
endmodule // strap_latch_chk

// ===== strap_board_model.sv
// Board strap resistors in front of the multifunction pins
`timescale 1ns/10ps
module strap_board_model
(
  // Clock, capture flag and strap setting
  input  wire logic        core_clk_i,
  input  wire logic        straps_valid_i,
  input  wire logic [15:0] strap_word_i,
  // Pin levels
  output logic      [15:0] pin_word_o
);
  // Straps stand until capture; then live traffic flips the pins each cycle
  always @(posedge core_clk_i)
    pin_word_o <= straps_valid_i ? ~pin_word_o : strap_word_i;
endmodule // strap_board_model

// ===== testbench.sv
// Self-checking testbench for the hub reset strap latch
`timescale 1ns/10ps
module testbench;
  logic        core_clk_i = 1'b0;
  logic        rst_b_i = 1'b0;
  logic        strapping_enable_i = 1'b1;
  logic [15:0] strap_word = 16'h0000;
  logic [3:0]  power_request_i = 4'h0;
  logic [3:0]  overcurrent_sense_low_i = 4'hF;
  wire  [15:0] pin_word;
  wire         straps_valid_o, compound_device_o;
  wire  [3:0]  port_disabled_o, charge_support_o, ext_power_ctrl_o, fixed_port_mask_o, port_power_enable_o, overcurrent_o;
  wire  [1:0]  fixed_port_code_o, config_method_sel_o;
  int          fails = 0;
  int          tests_run = 0;
  int          cycles = 0;
  // Clock and hang guard
  always #2 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      fails++;
      give_verdict;
    end
  end
  // Design and board
  hub_reset_strap_latch hub_reset_strap_latch_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .strapping_enable_i(strapping_enable_i), .port_off_strap_plus_i(pin_word[15:12]),
    .port_off_strap_minus_i(pin_word[11:8]), .charge_support_strap_i(pin_word[7:4]),
    .fixed_port_code_bit1_i(pin_word[3]), .fixed_port_code_bit0_i(pin_word[2]),
    .config_method_sel1_i(pin_word[1]), .config_method_sel0_i(pin_word[0]),
    .power_request_i(power_request_i), .overcurrent_sense_low_i(overcurrent_sense_low_i),
    .straps_valid_o(straps_valid_o), .port_disabled_o(port_disabled_o), .charge_support_o(charge_support_o),
    .ext_power_ctrl_o(ext_power_ctrl_o), .fixed_port_code_o(fixed_port_code_o),
    .fixed_port_mask_o(fixed_port_mask_o), .compound_device_o(compound_device_o),
    .config_method_sel_o(config_method_sel_o), .port_power_enable_o(port_power_enable_o),
    .overcurrent_o(overcurrent_o));
  strap_board_model strap_board_model_inst (.core_clk_i(core_clk_i), .straps_valid_i(straps_valid_o),
    .strap_word_i(strap_word), .pin_word_o(pin_word));
  task automatic check(input logic [3:0] seen, input logic [3:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("fails %0d tests_run %0d", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Reset with given straps, then judge results while the pins toggle
  task automatic strap_case(input logic [15:0] w, input logic en, input int hold);
    strap_word = w;
    strapping_enable_i = en;
    rst_b_i = 1'b0;
    repeat (hold) @(negedge core_clk_i);
    rst_b_i = 1'b1;
    for (int i = 0; i < 20 && straps_valid_o !== 1'b1; i++) @(negedge core_clk_i);
    repeat (4) @(negedge core_clk_i);
    check(straps_valid_o, 4'h1);
    check(port_disabled_o, en ? w[15:12] & w[11:8] : 4'h0);
    check(charge_support_o, en ? w[7:4] : 4'h0);
    check(ext_power_ctrl_o, en ? w[7:4] : 4'h0);
    check(fixed_port_code_o, w[3:2]);
    check(fixed_port_mask_o, {1'b0, &w[3:2], w[3], |w[3:2]});
    check(compound_device_o, |w[3:2]);
    check(config_method_sel_o, w[1:0]);
  endtask
  // Power on non-disabled ports, then over-current on the first port
  task automatic power_case;
    power_request_i = 4'hF;
    repeat (2) @(negedge core_clk_i);
    check(port_power_enable_o, 4'h5);
    overcurrent_sense_low_i = 4'hE;
    repeat (5) @(negedge core_clk_i);
    check(overcurrent_o, 4'h1);
    check(port_power_enable_o, 4'h4);
    overcurrent_sense_low_i = 4'hF;
    repeat (2) @(negedge core_clk_i);
    check(overcurrent_o, 4'h0);
    check(port_power_enable_o, 4'h5);
  endtask
  initial
  begin
    strap_case(16'h3561, 1'b1, 16);
    strap_case(16'hCF96, 1'b0, 250);
    strap_case(16'hFFFB, 1'b1, 250);
    strap_case(16'hAF0C, 1'b1, 250);
    power_case;
    give_verdict;
  end
endmodule // testbench
bind hub_reset_strap_latch strap_latch_chk chk_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .power_request_i(power_request_i), .overcurrent_sense_low_i(overcurrent_sense_low_i),
  .straps_valid_o(straps_valid_o), .port_disabled_o(port_disabled_o), .charge_support_o(charge_support_o),
  .ext_power_ctrl_o(ext_power_ctrl_o), .fixed_port_code_o(fixed_port_code_o),
  .fixed_port_mask_o(fixed_port_mask_o), .compound_device_o(compound_device_o),
  .config_method_sel_o(config_method_sel_o), .port_power_enable_o(port_power_enable_o),
  .overcurrent_o(overcurrent_o));
